// ==== verilog/ofp_pkg.sv ====
// package: constants, carriers and helpers for the flash programming sequencer
package ofp_pkg;
    // core clock
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_NS = 100;
    // mode selection: a quiet time on the programming-voltage pin closes the count
    localparam int SEL_QUIET_US = 1000;
    localparam int SEL_QUIET_CYC = SEL_QUIET_US * 1000 / CLK_NS;
    localparam logic [3:0] PULSES_SIO = 4'h0;
    localparam logic [3:0] PULSES_P0 = 4'h1;
    localparam logic [3:0] PULSES_UART = 4'h8;
    localparam logic [3:0] PCNT_MAX = 4'hf;
    // flash array
    localparam int FLASH_BYTES = 16384;
    localparam logic [13:0] FLASH_LAST = 14'h3fff;
    localparam logic [7:0] ERASED = 8'hff;
    // command and reply bytes
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_BLANK = 8'h30;
    localparam logic [7:0] CMD_WRITE = 8'h40;
    localparam logic [7:0] CMD_VERIFY = 8'h50;
    localparam logic [7:0] RSP_ACK = 8'h3c;
    localparam logic [7:0] RSP_NAK = 8'hc3;
    // serial framing
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] UART_BITS = 4'h9;
    localparam int BAUD_0 = 9600;
    localparam int BAUD_1 = 19200;
    localparam int BAUD_2 = 38400;
    localparam int BAUD_3 = 76800;

    typedef enum logic [1:0] {
        OFP_LINK_NONE,
        OFP_LINK_SIO,
        OFP_LINK_P0,
        OFP_LINK_UART
    } ofp_link_t;

    typedef struct packed {
        logic erase;
        logic wr;
        logic [13:0] addr;
        logic [7:0] wdata;
    } ofp_freq_t;

    // clock_in cycles per asynchronous bit
    function automatic logic [10:0] baud_div(input logic [1:0] sel);
        unique case (sel)
            2'h0: return 11'(CLK_HZ / BAUD_0);
            2'h1: return 11'(CLK_HZ / BAUD_1);
            2'h2: return 11'(CLK_HZ / BAUD_2);
            default: return 11'(CLK_HZ / BAUD_3);
        endcase
    endfunction : baud_div
endpackage : ofp_pkg

// ==== verilog/ofp_sync_shift.sv ====
// module: three-wire clocked serial shifter running on the programmer's clock
`timescale 1ns/1ps
module ofp_sync_shift (
    // link side
    input wire logic sclk_in,
    input wire logic sdi_in,
    output logic sdo_out,
    // core side
    input wire logic en_in,
    input wire logic [7:0] tx_byte_in,
    input wire logic tx_tgl_in,
    output logic rx_tgl_out,
    output logic [7:0] rx_byte_out
);
    logic en_m_q;
    logic en_q;
    logic tg_m_q;
    logic tg_q;
    logic ack_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;

    // no ratio to clock_in assumed; any serial clock rate works
    always_ff @(posedge sclk_in) begin
        en_m_q <= en_in;
        en_q <= en_m_q;
        tg_m_q <= tx_tgl_in;
        tg_q <= tg_m_q;
    end

    // receive msb first; byte handed over by toggle, hold stays until next byte
    always_ff @(posedge sclk_in) begin
        if (!en_q) begin
            bit_q <= 3'h0;
            rx_tgl_out <= 1'b0;
        end else begin
            sh_q <= {sh_q[6:0], sdi_in};
            bit_q <= bit_q + 3'h1;
            if (bit_q == ofp_pkg::BIT_LAST) begin
                rx_byte_out <= {sh_q[6:0], sdi_in};
                rx_tgl_out <= !rx_tgl_out;
            end
        end
    end

    // reply loaded only on a byte boundary, idle bytes read as all ones
    always_ff @(posedge sclk_in) begin
        if (!en_q) begin
            ack_q <= tg_q;
            tx_q <= 8'hff;
        end else if (bit_q == ofp_pkg::BIT_LAST) begin
            tx_q <= (tg_q != ack_q) ? tx_byte_in : 8'hff;
            ack_q <= tg_q;
        end else begin
            tx_q <= {tx_q[6:0], 1'b1};
        end
    end

    assign sdo_out = tx_q[7];
endmodule : ofp_sync_shift

// ==== verilog/ofp_flash_array.sv ====
// module: flash array storage with bulk erase and program-by-and
`timescale 1ns/1ps
module ofp_flash_array (
    // clock
    input wire logic clock_in,
    // request and read data
    input wire ofp_pkg::ofp_freq_t req_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem_q [ofp_pkg::FLASH_BYTES];

    // programming only clears bits, as real flash cells do
    always_ff @(posedge clock_in) begin
        if (req_in.erase) begin
            for (int i = 0; i < ofp_pkg::FLASH_BYTES; i++) begin
                mem_q[i] <= ofp_pkg::ERASED;
            end
        end else if (req_in.wr) begin
            mem_q[req_in.addr] <= mem_q[req_in.addr] & req_in.wdata;
        end
    end

    always_ff @(posedge clock_in) begin
        rdata_out <= mem_q[req_in.addr];
    end
endmodule : ofp_flash_array

// ==== verilog/ofp_flash_prog.sv ====
// module: on-board serial flash programming entry and command sequencer
`timescale 1ns/1ps
module ofp_flash_prog #(
    parameter int SEL_QUIET = ofp_pkg::SEL_QUIET_CYC
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // programming-voltage pin
    input wire logic vpp_pulse_in,
    // serial unit pins, shared with the asynchronous link
    input wire logic sync_serial_clock_pin_in,
    input wire logic sync_serial_in_pin_in,
    output logic sync_serial_out_pin_out,
    output logic sync_serial_out_pin_oe_out,
    // port 0 pins
    input wire logic port0_bit0_key_line_in,
    input wire logic port0_bit2_key_line_in,
    output logic port0_bit1_key_line_out,
    output logic port0_bit1_key_line_oe_out,
    // asynchronous rate pick
    input wire logic [1:0] baud_sel_in,
    // status
    output ofp_pkg::ofp_link_t link_mode_out,
    output logic busy_out,
    output logic pass_out
);
    typedef enum logic [1:0] {
        S_IDLE,
        S_COUNT,
        S_DONE
    } ofp_sel_t;

    typedef enum logic [3:0] {
        C_IDLE,
        C_AH,
        C_AL,
        C_NH,
        C_NL,
        C_WDATA,
        C_VDATA,
        C_BLANK,
        C_REPLY
    } ofp_cmd_t;

    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);

    logic [1:0] vpp_s_q;
    logic [1:0] rxd_s_q;
    logic [1:0] bm_q;
    logic [1:0] baud_q;
    logic vpp_d_q;
    logic vpp_rise;
    ofp_sel_t sel_q;
    logic [3:0] pcnt_q;
    logic [15:0] quiet_q;
    ofp_pkg::ofp_link_t link_mode_q;
    logic sio_en;
    logic p0_en;
    logic uart_en;
    logic [2:0] sio_tg_q;
    logic [2:0] p0_tg_q;
    logic sio_tgl;
    logic p0_tgl;
    logic [7:0] sio_byte;
    logic [7:0] p0_byte;
    logic sio_sdo;
    logic p0_sdo;
    logic [7:0] tx_hold_q;
    logic tx_tgl_q;
    logic urx_busy_q;
    logic [10:0] urx_tmr_q;
    logic [3:0] urx_bit_q;
    logic [7:0] urx_sh_q;
    logic urx_v_q;
    logic utx_busy_q;
    logic [10:0] utx_tmr_q;
    logic [3:0] utx_bit_q;
    logic [9:0] utx_sh_q;
    logic rx_v;
    logic [7:0] rx_b;
    ofp_cmd_t cmd_q;
    logic [7:0] hi_q;
    logic wr_op_q;
    logic [13:0] addr_q;
    logic [15:0] cnt_q;
    logic fail_q;
    logic pass_q;
    logic tx_go;
    logic [7:0] tx_byte;
    ofp_pkg::ofp_freq_t freq;
    logic [7:0] flash_rd;

    // pin inputs sampled on clock_in pass two flops before any logic reads them; the clocked links take their pins direct
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            vpp_s_q <= 2'h0;
            rxd_s_q <= 2'h3;
            bm_q <= 2'h0;
            baud_q <= 2'h0;
            vpp_d_q <= 1'b0;
        end else begin
            vpp_s_q <= {vpp_s_q[0], vpp_pulse_in};
            rxd_s_q <= {rxd_s_q[0], sync_serial_in_pin_in};
            bm_q <= baud_sel_in;
            baud_q <= bm_q;
            vpp_d_q <= vpp_s_q[1];
        end
    end

    assign vpp_rise = vpp_s_q[1] && !vpp_d_q;

    // first rise enters selection, further rises are counted pulses
    // a long low anywhere drops back out of programming mode
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sel_q <= S_IDLE;
            pcnt_q <= 4'h0;
            quiet_q <= 16'h0;
            link_mode_q <= ofp_pkg::OFP_LINK_NONE;
        end else begin
            unique case (sel_q)
                S_IDLE: begin
                    if (vpp_rise) begin
                        sel_q <= S_COUNT;
                        pcnt_q <= 4'h0;
                        quiet_q <= 16'h0;
                    end
                end
                S_COUNT: begin
                    if (vpp_rise) begin
                        if (pcnt_q != ofp_pkg::PCNT_MAX) begin
                            pcnt_q <= pcnt_q + 4'h1;
                        end
                        quiet_q <= 16'h0;
                    end else if (quiet_q == 16'(SEL_QUIET - 1)) begin
                        quiet_q <= 16'h0;
                        if (!vpp_s_q[1]) begin
                            sel_q <= S_IDLE;
                        end else begin
                            sel_q <= S_DONE;
                            unique case (pcnt_q)
                                ofp_pkg::PULSES_SIO: link_mode_q <= ofp_pkg::OFP_LINK_SIO;
                                ofp_pkg::PULSES_P0: link_mode_q <= ofp_pkg::OFP_LINK_P0;
                                ofp_pkg::PULSES_UART: link_mode_q <= ofp_pkg::OFP_LINK_UART;
                                default: link_mode_q <= ofp_pkg::OFP_LINK_NONE;
                            endcase
                        end
                    end else begin
                        quiet_q <= quiet_q + 16'h1;
                    end
                end
                S_DONE: begin
                    if (vpp_s_q[1]) begin
                        quiet_q <= 16'h0;
                    end else if (quiet_q == 16'(SEL_QUIET - 1)) begin
                        sel_q <= S_IDLE;
                        link_mode_q <= ofp_pkg::OFP_LINK_NONE;
                    end else begin
                        quiet_q <= quiet_q + 16'h1;
                    end
                end
                default: sel_q <= S_IDLE;
            endcase
        end
    end

    // only the selected link is ever enabled
    assign sio_en = (sel_q == S_DONE) && (link_mode_q == ofp_pkg::OFP_LINK_SIO);
    assign p0_en = (sel_q == S_DONE) && (link_mode_q == ofp_pkg::OFP_LINK_P0);
    assign uart_en = (sel_q == S_DONE) && (link_mode_q == ofp_pkg::OFP_LINK_UART);

    // each clocked link runs in its own pin clock domain
    ofp_sync_shift u_sio (
        .sclk_in(sync_serial_clock_pin_in),
        .sdi_in(sync_serial_in_pin_in),
        .sdo_out(sio_sdo),
        .en_in(sio_en),
        .tx_byte_in(tx_hold_q),
        .tx_tgl_in(tx_tgl_q),
        .rx_tgl_out(sio_tgl),
        .rx_byte_out(sio_byte)
    );

    // port 0: bit 0 clock, bit 2 data in, bit 1 data out
    ofp_sync_shift u_p0 (
        .sclk_in(port0_bit0_key_line_in),
        .sdi_in(port0_bit2_key_line_in),
        .sdo_out(p0_sdo),
        .en_in(p0_en),
        .tx_byte_in(tx_hold_q),
        .tx_tgl_in(tx_tgl_q),
        .rx_tgl_out(p0_tgl),
        .rx_byte_out(p0_byte)
    );

    // byte toggles cross back by two flops, third flop finds the change
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sio_tg_q <= 3'h0;
            p0_tg_q <= 3'h0;
        end else begin
            sio_tg_q <= {sio_tg_q[1:0], sio_tgl};
            p0_tg_q <= {p0_tg_q[1:0], p0_tgl};
        end
    end

    // asynchronous receive, lsb first, sampled mid-bit
    always_ff @(posedge clock_in) begin
        if (srst_in || !uart_en) begin
            urx_busy_q <= 1'b0;
            urx_v_q <= 1'b0;
            urx_tmr_q <= 11'h0;
            urx_bit_q <= 4'h0;
        end else begin
            urx_v_q <= 1'b0;
            if (!urx_busy_q) begin
                if (!rxd_s_q[1]) begin
                    urx_busy_q <= 1'b1;
                    urx_tmr_q <= ofp_pkg::baud_div(baud_q) >> 1;
                    urx_bit_q <= 4'h0;
                end
            end else if (urx_tmr_q != 11'h0) begin
                urx_tmr_q <= urx_tmr_q - 11'h1;
            end else begin
                urx_tmr_q <= ofp_pkg::baud_div(baud_q) - 11'h1;
                urx_bit_q <= urx_bit_q + 4'h1;
                // a start bit gone high was a glitch; a low stop bit drops the byte
                if (urx_bit_q == 4'h0 && rxd_s_q[1]) begin
                    urx_busy_q <= 1'b0;
                end else if (urx_bit_q == ofp_pkg::UART_BITS) begin
                    urx_busy_q <= 1'b0;
                    urx_v_q <= rxd_s_q[1];
                end else begin
                    urx_sh_q <= {rxd_s_q[1], urx_sh_q[7:1]};
                end
            end
        end
    end

    // asynchronous transmit: start, eight data bits, stop
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            utx_busy_q <= 1'b0;
            utx_sh_q <= 10'h3ff;
            utx_tmr_q <= 11'h0;
            utx_bit_q <= 4'h0;
        end else if (!utx_busy_q) begin
            if (tx_go && uart_en) begin
                utx_busy_q <= 1'b1;
                utx_sh_q <= {1'b1, tx_byte, 1'b0};
                utx_tmr_q <= ofp_pkg::baud_div(baud_q) - 11'h1;
                utx_bit_q <= 4'h0;
            end
        end else if (utx_tmr_q != 11'h0) begin
            utx_tmr_q <= utx_tmr_q - 11'h1;
        end else begin
            utx_sh_q <= {1'b1, utx_sh_q[9:1]};
            utx_tmr_q <= ofp_pkg::baud_div(baud_q) - 11'h1;
            utx_bit_q <= utx_bit_q + 4'h1;
            if (utx_bit_q == ofp_pkg::UART_BITS) begin
                utx_busy_q <= 1'b0;
            end
        end
    end

    // received bytes come from the chosen link only
    always_comb begin
        rx_v = 1'b0;
        rx_b = urx_sh_q;
        if (sio_en) begin
            rx_v = sio_tg_q[2] ^ sio_tg_q[1];
            rx_b = sio_byte;
        end else if (p0_en) begin
            rx_v = p0_tg_q[2] ^ p0_tg_q[1];
            rx_b = p0_byte;
        end else if (uart_en) begin
            rx_v = urx_v_q;
        end
    end

    // reply handed to the clocked links by hold word plus toggle
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            tx_hold_q <= 8'hff;
            tx_tgl_q <= 1'b0;
        end else if (tx_go && !uart_en) begin
            tx_hold_q <= tx_byte;
            tx_tgl_q <= !tx_tgl_q;
        end
    end

    assign tx_go = (cmd_q == C_REPLY);
    assign tx_byte = fail_q ? ofp_pkg::RSP_NAK : ofp_pkg::RSP_ACK;

    // flash requests
    always_comb begin
        freq.addr = addr_q;
        freq.wdata = rx_b;
        freq.erase = (cmd_q == C_IDLE) && rx_v && (rx_b == ofp_pkg::CMD_ERASE);
        freq.wr = (cmd_q == C_WDATA) && rx_v;
    end

    ofp_flash_array u_array (
        .clock_in(clock_in),
        .req_in(freq),
        .rdata_out(flash_rd)
    );

    // command sequencer: every operation is bytes in, one reply out
    always_ff @(posedge clock_in) begin
        if (srst_in || (sel_q != S_DONE)) begin
            cmd_q <= C_IDLE;
            hi_q <= 8'h0;
            wr_op_q <= 1'b0;
            addr_q <= 14'h0;
            cnt_q <= 16'h0;
            fail_q <= 1'b0;
        end else begin
            unique case (cmd_q)
                C_IDLE: begin
                    if (rx_v) begin
                        fail_q <= 1'b0;
                        addr_q <= 14'h0;
                        cnt_q <= 16'h0;
                        unique case (rx_b)
                            ofp_pkg::CMD_ERASE: cmd_q <= C_REPLY;
                            ofp_pkg::CMD_BLANK: cmd_q <= C_BLANK;
                            ofp_pkg::CMD_WRITE: cmd_q <= C_AH;
                            ofp_pkg::CMD_VERIFY: begin
                                cmd_q <= C_VDATA;
                                cnt_q <= 16'(ofp_pkg::FLASH_BYTES);
                            end
                            default: begin
                                cmd_q <= C_REPLY;
                                fail_q <= 1'b1;
                            end
                        endcase
                    end
                end
                C_AH: if (rx_v) begin
                    hi_q <= rx_b;
                    cmd_q <= C_AL;
                end
                // upper address bits beyond the array are dropped
                C_AL: if (rx_v) begin
                    addr_q <= {hi_q[5:0], rx_b};
                    cmd_q <= C_NH;
                end
                C_NH: if (rx_v) begin
                    hi_q <= rx_b;
                    cmd_q <= C_NL;
                end
                C_NL: if (rx_v) begin
                    cnt_q <= {hi_q, rx_b};
                    cmd_q <= ({hi_q, rx_b} == 16'h0) ? C_REPLY : C_WDATA;
                end
                C_WDATA: if (rx_v) begin
                    addr_q <= addr_q + 14'h1;
                    cnt_q <= cnt_q - 16'h1;
                    if (cnt_q == 16'h1) begin
                        cmd_q <= C_REPLY;
                    end
                end
                C_VDATA: if (rx_v) begin
                    if (flash_rd != rx_b) begin
                        fail_q <= 1'b1;
                    end
                    addr_q <= addr_q + 14'h1;
                    cnt_q <= cnt_q - 16'h1;
                    if (cnt_q == 16'h1) begin
                        cmd_q <= C_REPLY;
                    end
                end
                // read data lags the address by one cycle
                C_BLANK: begin
                    addr_q <= addr_q + 14'h1;
                    cnt_q <= cnt_q + 16'h1;
                    if (cnt_q != 16'h0 && flash_rd != ofp_pkg::ERASED) begin
                        fail_q <= 1'b1;
                    end
                    if (cnt_q == 16'(ofp_pkg::FLASH_BYTES)) begin
                        cmd_q <= C_REPLY;
                    end
                end
                C_REPLY: cmd_q <= C_IDLE;
                default: cmd_q <= C_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pass_q <= 1'b0;
        end else if (tx_go) begin
            pass_q <= !fail_q;
        end
    end

    // pins not used by the chosen link stay undriven, as after reset
    assign sync_serial_out_pin_oe_out = sio_en || uart_en;
    assign port0_bit1_key_line_oe_out = p0_en;
    assign sync_serial_out_pin_out = uart_en ? utx_sh_q[0] : (sio_en && sio_sdo);
    assign port0_bit1_key_line_out = p0_en && p0_sdo;
    assign link_mode_out = link_mode_q;
    assign busy_out = (cmd_q != C_IDLE);
    assign pass_out = pass_q;

    a_mode_pick: assert property (
        (sel_q == S_COUNT && !vpp_rise && vpp_s_q[1] && quiet_q == 16'(SEL_QUIET - 1)
            && pcnt_q == ofp_pkg::PULSES_UART)
        |=> (sel_q == S_DONE && link_mode_q == ofp_pkg::OFP_LINK_UART))
        else $error("eight pulses did not pick the asynchronous link");

    a_port0_pins: assert property (
        port0_bit1_key_line_oe_out
        |-> (link_mode_q == ofp_pkg::OFP_LINK_P0 && !sync_serial_out_pin_oe_out))
        else $error("port 0 data out driven outside port 0 mode");

    a_unused_pins: assert property (
        (sel_q != S_DONE) |-> !(sync_serial_out_pin_oe_out || port0_bit1_key_line_oe_out))
        else $error("pin driven before a link was chosen");

    a_erase_once: assert property (
        freq.erase |=> (cmd_q == C_REPLY && !freq.erase && !fail_q))
        else $error("erase did not complete in one operation");

    a_blank_scan: assert property (
        $rose(cmd_q == C_BLANK) |-> (cmd_q == C_BLANK)[*8])
        else $error("blank check left the scan early");

    a_write_count: assert property (
        (cmd_q == C_WDATA && rx_v && cnt_q == 16'h1) |=> (cmd_q == C_REPLY))
        else $error("write did not end after the last byte");

    a_verify_miss: assert property (
        (cmd_q == C_VDATA && rx_v && flash_rd != rx_b) |=> fail_q)
        else $error("verify mismatch not reported");

    a_baud_rate: assert property (
        (utx_busy_q && $stable(baud_q)) |-> (utx_tmr_q < ofp_pkg::baud_div(baud_q)))
        else $error("bit timer beyond the chosen rate");

    a_addr_wrap: assert property (
        (freq.wr && addr_q == ofp_pkg::FLASH_LAST) |=> (addr_q == 14'h0))
        else $error("address ran past the end of the array");

    a_link_gate: assert property (
        (rx_v || freq.erase || freq.wr) |-> (sel_q == S_DONE && link_mode_q != ofp_pkg::OFP_LINK_NONE))
        else $error("traffic accepted before link selection");
endmodule : ofp_flash_prog

// ==== testbench/ofp_prog_model.sv ====
// file: programmer model, three-wire link with its own clock and asynchronous frames
`timescale 1ns/1ps
module ofp_prog_model (
    // link pins
    output logic sclk_out,
    output logic sdo_out,
    input wire logic sdi_in
);
    // bench runs the asynchronous link at the fastest rate
    localparam int UBIT = ofp_pkg::CLK_HZ / ofp_pkg::BAUD_3 * ofp_pkg::CLK_NS;
    initial begin
        sclk_out = 1'b1;
        sdo_out = 1'b1;
    end
    // exactly two bare clocks carry the enable over; the bit count runs from the third
    task automatic wake;
        repeat (2) begin
            sclk_out = 1'b0;
            #7.5;
            sclk_out = 1'b1;
            #7.5;
        end
        #1000;
    endtask : wake
    // one byte each way, msb first; clock stands still between frames
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk_out = 1'b0;
            sdo_out = tx[i];
            #7.5;
            rx[i] = sdi_in;
            sclk_out = 1'b1;
            #7.5;
        end
        // released line shows the inverse, never a stale bit
        sdo_out = ~tx[0];
        #1000;
    endtask : xfer
    // asynchronous frame out, reply frame sampled mid-bit; a silent line times out
    task automatic uart(input logic [7:0] tx, output logic [7:0] rx, output logic tmo);
        logic [8:0] f;
        int n;
        f = {tx, 1'b0};
        rx = 8'h00;
        tmo = 1'b1;
        for (int i = 0; i < 9; i++) begin
            sdo_out = f[i];
            #(UBIT);
        end
        // stop bit stays up; the reply starts inside it
        sdo_out = 1'b1;
        n = 0;
        while (sdi_in !== 1'b0 && n < 64) begin
            #(UBIT / 16);
            n++;
        end
        if (n < 64) begin
            tmo = 1'b0;
            #(UBIT + UBIT / 2);
            for (int i = 0; i < 8; i++) begin
                rx[i] = sdi_in;
                #(UBIT);
            end
        end
    endtask : uart
endmodule : ofp_prog_model

// ==== testbench/tb_onboard_flash_serial_programming.sv ====
// file: testbench for the flash programming sequencer
`timescale 1ns/1ps
module tb_onboard_flash_serial_programming;
    localparam int QUIET = 40;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic vpp_q = 1'b0;
    logic use_a = 1'b0;
    logic [1:0] baud = 2'h0;
    logic m_clk, m_do, so_a, oe_a, so_b, oe_b, busy, pass;
    ofp_pkg::ofp_link_t mode;
    int bad_count = 0;
    int n_checks = 0;
    always #50 clock_in = ~clock_in;
    // the idle link sees inverted data so a deaf link can be told apart
    ofp_flash_prog #(.SEL_QUIET(QUIET)) dut (
        .clock_in(clock_in), .srst_in(srst_in), .vpp_pulse_in(vpp_q),
        .sync_serial_clock_pin_in(m_clk), .sync_serial_in_pin_in(use_a ? m_do : ~m_do),
        .sync_serial_out_pin_out(so_a), .sync_serial_out_pin_oe_out(oe_a),
        .port0_bit0_key_line_in(m_clk), .port0_bit2_key_line_in(use_a ? ~m_do : m_do),
        .port0_bit1_key_line_out(so_b), .port0_bit1_key_line_oe_out(oe_b),
        .baud_sel_in(baud), .link_mode_out(mode), .busy_out(busy), .pass_out(pass));
    ofp_prog_model prog (.sclk_out(m_clk), .sdo_out(m_do), .sdi_in(use_a ? so_a : so_b));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic select_link(input int pulses);
        vpp_q <= 1'b1;
        repeat (10) @(posedge clock_in);
        for (int i = 0; i < pulses; i++) begin
            vpp_q <= 1'b0;
            repeat (10) @(posedge clock_in);
            vpp_q <= 1'b1;
            repeat (10) @(posedge clock_in);
        end
        repeat (QUIET + 10) @(posedge clock_in);
    endtask : select_link
    task automatic leave;
        vpp_q <= 1'b0;
        repeat (QUIET + 10) @(posedge clock_in);
        chk("link after exit", 8'h0, 8'(mode));
    endtask : leave
    task automatic cmd(input logic [7:0] b [], input logic [7:0] exp, input int lim);
        logic [7:0] r;
        int n;
        foreach (b[i]) prog.xfer(b[i], r);
        n = 0;
        while (busy !== 1'b0 && n < lim) begin
            @(posedge clock_in);
            n++;
        end
        chk("busy wait", 8'h0, 8'(n >= lim));
        if (n >= lim) end_of_test();
        repeat (3) @(posedge clock_in);
        // dummy bytes are commands too, so the flag is read before they arrive
        chk("pass flag", 8'(exp == ofp_pkg::RSP_ACK), 8'(pass));
        // reply loads during a dummy frame and shows in the next
        prog.xfer(8'hff, r);
        prog.xfer(8'hff, r);
        chk("reply", exp, r);
    endtask : cmd
    task automatic t_reset;
        chk("idle pins", 8'h0, {mode, oe_a, oe_b, so_a, so_b, busy, pass});
        $display("test reset done");
    endtask : t_reset
    task automatic t_modes;
        int cnt [4] = '{0, 1, 8, 3};
        ofp_pkg::ofp_link_t lk [4] = '{ofp_pkg::OFP_LINK_SIO, ofp_pkg::OFP_LINK_P0,
            ofp_pkg::OFP_LINK_UART, ofp_pkg::OFP_LINK_NONE};
        for (int i = 0; i < 4; i++) begin
            select_link(cnt[i]);
            chk("link mode", 8'(lk[i]), 8'(mode));
            chk("enables", {6'h0, lk[i][0], lk[i] == ofp_pkg::OFP_LINK_P0}, {6'h0, oe_a, oe_b});
            leave();
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_uart;
        logic [7:0] r;
        logic tmo;
        use_a <= 1'b1;
        baud <= 2'h3;
        select_link(8);
        prog.uart(ofp_pkg::CMD_ERASE, r, tmo);
        chk("uart erase reply", ofp_pkg::RSP_ACK, r);
        if (tmo) end_of_test();
        prog.uart(8'h77, r, tmo);
        chk("uart reply", ofp_pkg::RSP_NAK, r);
        if (tmo) end_of_test();
        leave();
        $display("test uart done");
    endtask : t_uart
    task automatic t_prog(input logic a, input int pulses);
        logic [7:0] wr [] = '{ofp_pkg::CMD_WRITE, 8'h3f, 8'hff, 8'h00, 8'h02, 8'hff, 8'h00};
        use_a <= a;
        select_link(pulses);
        prog.wake();
        cmd('{ofp_pkg::CMD_ERASE}, ofp_pkg::RSP_ACK, 20);
        cmd('{ofp_pkg::CMD_BLANK}, ofp_pkg::RSP_ACK, 20000);
        cmd(wr, ofp_pkg::RSP_ACK, 20);
        cmd('{ofp_pkg::CMD_BLANK}, ofp_pkg::RSP_NAK, 20000);
        cmd('{8'h77}, ofp_pkg::RSP_NAK, 20);
        leave();
        $display("test program with %0d pulses done", pulses);
    endtask : t_prog
    initial begin
        repeat (8) @(posedge clock_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        t_reset();
        t_modes();
        t_uart();
        t_prog(1'b0, 1);
        t_prog(1'b1, 0);
        end_of_test();
    end
endmodule : tb_onboard_flash_serial_programming
